// ===== core/ppt_top.sv
// Parallel port timing, address, pin enable and buffer status registers.
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ppt_top (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [1:0] host_idx,
	output logic [14:0] addr_pins,
	output logic [14:0] port_pin_owned,
	output logic chip_select_pin,
	output logic address_latch_high,
	output logic address_latch_low,
	output logic strobe_rd,
	output logic strobe_wr
);
	import ppt_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic [1:0] irqm;
		ppt_inc_e inc_sel;
		ppt_mode_e mode;
		logic [1:0] setup_wait;
		logic [3:0] strobe_wait;
		logic [1:0] hold_wait;
		logic [10:0] addr;
		logic cs;
		logic [14:0] pen;
		logic [1:0] cs_sel;
		logic [1:0] mux;
		logic cyc_wr;
		logic [31:0] rdata;
		logic [14:0] apin;
		logic [14:0] own;
		logic csp;
		logic alh;
		logic all;
		logic srd;
		logic swr;
	} ppt_top_s;
	ppt_top_s r_reg, r_next;

	ppt_seq_if sq ();
	logic [NBUF-1:0] in_full;
	logic [NBUF-1:0] out_empty;
	logic in_ovf;
	logic out_unf;
	logic master;
	logic cmd_start;
	logic [NBUF-1:0] sw_in_rd;
	logic [NBUF-1:0] sw_out_wr;
	logic clr_in_ovf;
	logic clr_out_unf;

	function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
		return wr && (a == ofs);
	endfunction

	// ==========================================================
	// Sequencer and flags
	assign master = r_reg.mode[1];
	assign cmd_start = wr_hit(reg_wr, reg_addr, OFS_CMD) && reg_wdata[CMD_START] && master && !sq.busy;
	assign sq.start = cmd_start;
	assign sq.is_write = reg_wdata[CMD_WRITE];
	assign sq.setup_w = r_reg.setup_wait;
	assign sq.strobe_w = r_reg.strobe_wait;
	assign sq.hold_w = r_reg.hold_wait;

	ppt_seq ppt_seq_inst (
		.clk_sys(clk_sys),
		.rst(rst),
		.sq(sq)
	);

	// Software side of the buffers arrives as command bits, since the data path lives elsewhere.
	assign sw_in_rd = wr_hit(reg_wr, reg_addr, OFS_CMD) ? reg_wdata[CMD_INRD_LSB+:NBUF] : '0;
	assign sw_out_wr = wr_hit(reg_wr, reg_addr, OFS_CMD) ? reg_wdata[CMD_OUTWR_LSB+:NBUF] : '0;
	assign clr_in_ovf = wr_hit(reg_wr, reg_addr, OFS_STAT) && !reg_wdata[ST_INOVF];
	assign clr_out_unf = wr_hit(reg_wr, reg_addr, OFS_STAT) && !reg_wdata[ST_OUTUNF];

	ppt_flags ppt_flags_inst (
		.clk_sys(clk_sys),
		.rst(rst),
		.slave_en(!master),
		.host_wr(host_wr),
		.host_rd(host_rd),
		.host_idx(host_idx),
		.sw_in_rd(sw_in_rd),
		.sw_out_wr(sw_out_wr),
		.clr_in_ovf(clr_in_ovf),
		.clr_out_unf(clr_out_unf),
		.in_full(in_full),
		.out_empty(out_empty),
		.in_ovf(in_ovf),
		.out_unf(out_unf)
	);

	// ==========================================================
	// Next state
	always_comb begin
		logic [9:0] step;
		logic [31:0] w;
		step = (r_reg.inc_sel == INC_DOWN) ? 10'h3FF : 10'h001;
		w = 32'h0;
		r_next = r_reg;
		r_next.rdata = 32'h0;
		if (cmd_start) r_next.cyc_wr = reg_wdata[CMD_WRITE];

		// Address steps after each master cycle in the INC_UP and INC_DOWN step modes; a software write in the same cycle wins.
		if (sq.done && (r_reg.inc_sel == INC_UP || r_reg.inc_sel == INC_DOWN)) begin
			if (r_reg.cs_sel == CSEL_CHIP) begin
				r_next.addr[10:2] = r_reg.addr[10:2] + step[8:0];
			end else begin
				{r_next.cs, r_next.addr[10:2]} = {r_reg.cs, r_reg.addr[10:2]} + step;
			end
		end

		if (wr_hit(reg_wr, reg_addr, OFS_MODE)) begin
			r_next.irqm = reg_wdata[IRQM_LSB+:2];
			r_next.inc_sel = ppt_inc_e'(reg_wdata[STEP_LSB+:2]);
			r_next.mode = ppt_mode_e'(reg_wdata[MODE_LSB+:2]);
			r_next.setup_wait = reg_wdata[SETUP_LSB+:2];
			r_next.strobe_wait = reg_wdata[STRB_LSB+:4];
			r_next.hold_wait = reg_wdata[HOLD_LSB+:2];
		end
		if (wr_hit(reg_wr, reg_addr, OFS_ADDR)) begin
			r_next.addr = reg_wdata[10:0];
			r_next.cs = reg_wdata[ADDR_CS];
		end
		if (wr_hit(reg_wr, reg_addr, OFS_PEN)) begin
			r_next.pen[10:0] = reg_wdata[10:0];
			r_next.pen[PEN_A14] = reg_wdata[PEN_A14];
		end
		if (wr_hit(reg_wr, reg_addr, OFS_CTRL)) begin
			r_next.cs_sel = reg_wdata[CTRL_CSEL_LSB+:2];
			r_next.mux = reg_wdata[CTRL_MUX_LSB+:2];
		end

		// Read data, one cycle after the strobe; unmapped offsets read zero.
		if (reg_rd) begin
			unique case (reg_addr)
				OFS_MODE: begin
					w[MODE_BUSY] = sq.busy;
					w[IRQM_LSB+:2] = r_reg.irqm;
					w[STEP_LSB+:2] = r_reg.inc_sel;
					w[MODE_LSB+:2] = r_reg.mode;
					w[SETUP_LSB+:2] = r_reg.setup_wait;
					w[STRB_LSB+:4] = r_reg.strobe_wait;
					w[HOLD_LSB+:2] = r_reg.hold_wait;
				end
				OFS_ADDR: begin
					w[10:0] = r_reg.addr;
					w[ADDR_CS] = r_reg.cs;
				end
				OFS_PEN: begin
					w[10:0] = r_reg.pen[10:0];
					w[PEN_A14] = r_reg.pen[PEN_A14];
				end
				OFS_STAT: begin
					w[ST_INALL] = &in_full;
					w[ST_INOVF] = in_ovf;
					w[ST_INF_LSB+:NBUF] = in_full;
					w[ST_OUTALL] = &out_empty;
					w[ST_OUTUNF] = out_unf;
					w[ST_OUTE_LSB+:NBUF] = out_empty;
				end
				OFS_CTRL: begin
					w[CTRL_CSEL_LSB+:2] = r_reg.cs_sel;
					w[CTRL_MUX_LSB+:2] = r_reg.mux;
				end
				default: w = 32'h0;
			endcase
			r_next.rdata = w;
		end

		// Pin roles and values.
		r_next.own = 15'h0;
		r_next.own[10:0] = r_reg.pen[10:0];
		r_next.own[PEN_A14] = r_reg.pen[PEN_A14];
		r_next.apin = 15'h0;
		r_next.apin[10:2] = r_reg.addr[10:2] & r_reg.pen[10:2];
		if (r_reg.mux == MUX_NONE) begin
			r_next.apin[1:0] = r_reg.addr[1:0] & r_reg.pen[1:0];
		end
		r_next.apin[14] = r_reg.pen[PEN_A14] && r_reg.cs_sel != CSEL_CHIP && r_reg.cs;
		r_next.csp = r_reg.pen[PEN_A14] && r_reg.cs_sel == CSEL_CHIP && r_reg.cs;
		// Multiplexed address is latched during the setup phase.
		r_next.all = r_reg.pen[0] && r_reg.mux != MUX_NONE && sq.setup_on;
		r_next.alh = r_reg.pen[1] && r_reg.mux == MUX_FULL && sq.setup_on;
		if (r_reg.mode == MD_MASTER1) begin
			// Combined mode: one line gives direction for the whole cycle, the other enables.
			r_next.srd = sq.busy && !r_reg.cyc_wr;
			r_next.swr = sq.strobe_on;
		end else begin
			r_next.srd = sq.strobe_on && !r_reg.cyc_wr;
			r_next.swr = sq.strobe_on && r_reg.cyc_wr;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rdata = r_reg.rdata;
	assign addr_pins = r_reg.apin;
	assign port_pin_owned = r_reg.own;
	assign chip_select_pin = r_reg.csp;
	assign address_latch_high = r_reg.alh;
	assign address_latch_low = r_reg.all;
	assign strobe_rd = r_reg.srd;
	assign strobe_wr = r_reg.swr;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_cs_pin;
		(wr_hit(reg_wr, reg_addr, OFS_ADDR) && reg_wdata[ADDR_CS] && r_reg.pen[PEN_A14]
			&& r_reg.cs_sel == CSEL_CHIP
			&& !wr_hit(reg_wr, reg_addr, OFS_PEN) && !wr_hit(reg_wr, reg_addr, OFS_CTRL))
			|=> ##1 (chip_select_pin && !addr_pins[14]);
	endproperty
	a_cs_pin: assert property (p_cs_pin) else $error("chip select pin not driven");
	property p_cs_fixed;
		(sq.done && r_reg.cs_sel == CSEL_CHIP && !wr_hit(reg_wr, reg_addr, OFS_ADDR))
			|=> r_reg.cs == $past(r_reg.cs);
	endproperty
	a_cs_fixed: assert property (p_cs_fixed) else $error("chip select bit stepped");
	property p_in_all;
		(reg_rd && reg_addr == OFS_STAT) |=> reg_rdata[ST_INALL] == $past(&in_full);
	endproperty
	a_in_all: assert property (p_in_all) else $error("input summary wrong");
	property p_ovf;
		(!master && host_wr && in_full[host_idx]) |=> in_ovf;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not set");
	property p_unf;
		(!master && host_rd && out_empty[host_idx]) |=> out_unf;
	endproperty
	a_unf: assert property (p_unf) else $error("underflow not set");
	property p_pen;
		wr_hit(reg_wr, reg_addr, OFS_PEN) |=> ##1 port_pin_owned[10:2] == $past(reg_wdata[10:2], 2);
	endproperty
	a_pen: assert property (p_pen) else $error("pin ownership wrong");
	property p_obe_reset;
		$fell(rst) |-> out_empty == OUTE_RST;
	endproperty
	a_obe_reset: assert property (@(posedge clk_sys) p_obe_reset) else $error("empty flags not set at reset");
endmodule
`default_nettype wire

// ===== include/ppt_pkg.sv
// Shared constants and types for the parallel port timing, address and status block.
package ppt_pkg;
	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_PEN = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	localparam logic [7:0] OFS_CTRL = 8'h10;
	localparam logic [7:0] OFS_CMD = 8'h14;
	// ==========================================================
	// Field positions
	localparam int MODE_BUSY = 15;
	localparam int IRQM_LSB = 13;
	localparam int STEP_LSB = 11;
	localparam int MODE_LSB = 8;
	localparam int SETUP_LSB = 6;
	localparam int STRB_LSB = 2;
	localparam int HOLD_LSB = 0;
	localparam int ADDR_CS = 14;
	localparam int PEN_A14 = 14;
	localparam int ST_INALL = 15;
	localparam int ST_INOVF = 14;
	localparam int ST_INF_LSB = 8;
	localparam int ST_OUTALL = 7;
	localparam int ST_OUTUNF = 6;
	localparam int ST_OUTE_LSB = 0;
	localparam int CTRL_MUX_LSB = 11;
	localparam int CTRL_CSEL_LSB = 6;
	localparam int CMD_START = 16;
	localparam int CMD_WRITE = 17;
	localparam int CMD_INRD_LSB = 8;
	localparam int CMD_OUTWR_LSB = 0;
	// ==========================================================
	// Reset values, widths and the minimum strobe setting
	localparam int NBUF = 4;
	localparam logic [3:0] OUTE_RST = 4'hF;
	localparam logic [3:0] STRB_MIN = 4'h0;
	// ==========================================================
	// Encodings
	typedef enum logic [1:0] {MD_LEGACY = 2'h0, MD_ENH = 2'h1, MD_MASTER2 = 2'h2, MD_MASTER1 = 2'h3} ppt_mode_e;
	typedef enum logic [1:0] {INC_NONE = 2'h0, INC_UP = 2'h1, INC_DOWN = 2'h2, INC_SLAVE = 2'h3} ppt_inc_e;
	localparam logic [1:0] CSEL_CHIP = 2'h2;
	localparam logic [1:0] MUX_NONE = 2'h0;
	localparam logic [1:0] MUX_FULL = 2'h2;
	typedef enum logic [1:0] {PH_IDLE = 2'h0, PH_SETUP = 2'h1, PH_STROBE = 2'h3, PH_HOLD = 2'h2} ppt_phase_e;
endpackage

// ===== include/ppt_seq_if.sv
// Interface between the register top and the master cycle sequencer.
`timescale 1ns/1ps
`default_nettype none
interface ppt_seq_if;
	logic start;
	logic is_write;
	logic [1:0] setup_w;
	logic [3:0] strobe_w;
	logic [1:0] hold_w;
	logic busy;
	logic setup_on;
	logic strobe_on;
	logic done;
	modport seq (input start, is_write, setup_w, strobe_w, hold_w, output busy, setup_on, strobe_on, done);
	modport ctl (output start, is_write, setup_w, strobe_w, hold_w, input busy, setup_on, strobe_on, done);
endinterface
`default_nettype wire

// ===== core/ppt_seq.sv
// Master cycle sequencer: setup, strobe and hold phases counted in clock periods.
`timescale 1ns/1ps
`default_nettype none
module ppt_seq (
	input wire logic clk_sys,
	input wire logic rst,
	ppt_seq_if.seq sq
);
	import ppt_pkg::*;
	typedef struct packed {
		ppt_phase_e ph;
		logic [3:0] cnt;
		logic [3:0] stb;
		logic [2:0] hld;
		logic done;
		logic [4:0] run;
		logic [4:0] exp_stb;
	} ppt_seq_s;
	ppt_seq_s r_reg, r_next;

	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		r_next.run = (r_reg.ph == PH_STROBE) ? r_reg.run + 5'h1 : 5'h0;
		unique case (r_reg.ph)
			PH_IDLE: if (sq.start) begin
				r_next.ph = PH_SETUP;
				r_next.exp_stb = {1'b0, sq.strobe_w} + 5'h1;
				if (sq.strobe_w == STRB_MIN) begin
					// Minimum strobe forces one setup clock and a fixed hold.
					r_next.cnt = 4'h0;
					r_next.stb = 4'h0;
					r_next.hld = sq.is_write ? 3'h1 : 3'h0;
				end else begin
					r_next.cnt = {2'h0, sq.setup_w};
					r_next.stb = sq.strobe_w;
					r_next.hld = sq.is_write ? {1'b0, sq.hold_w} + 3'h1 : {1'b0, sq.hold_w};
				end
			end
			PH_SETUP: if (r_reg.cnt == 4'h0) begin
				r_next.ph = PH_STROBE;
				r_next.cnt = r_reg.stb;
			end else begin
				r_next.cnt = r_reg.cnt - 4'h1;
			end
			PH_STROBE: if (r_reg.cnt != 4'h0) begin
				r_next.cnt = r_reg.cnt - 4'h1;
			end else if (r_reg.hld == 3'h0) begin
				r_next.ph = PH_IDLE;
				r_next.done = 1'b1;
			end else begin
				r_next.ph = PH_HOLD;
				r_next.cnt = {1'b0, r_reg.hld - 3'h1};
			end
			PH_HOLD: if (r_reg.cnt == 4'h0) begin
				r_next.ph = PH_IDLE;
				r_next.done = 1'b1;
			end else begin
				r_next.cnt = r_reg.cnt - 4'h1;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign sq.busy = r_reg.ph != PH_IDLE;
	assign sq.setup_on = r_reg.ph == PH_SETUP;
	assign sq.strobe_on = r_reg.ph == PH_STROBE;
	assign sq.done = r_reg.done;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_one_setup;
		sq.setup_on ##1 sq.strobe_on;
	endsequence
	sequence s_wr_long;
		sq.setup_on ##1 sq.strobe_on [*2] ##1 (r_reg.ph == PH_HOLD) [*4] ##1 !sq.busy;
	endsequence
	property p_strobe_len;
		$fell(sq.strobe_on) |-> r_reg.run == r_reg.exp_stb;
	endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");
	property p_min_read;
		(!sq.busy && sq.start && sq.strobe_w == 4'h0 && !sq.is_write) |=> s_one_setup ##1 !sq.busy;
	endproperty
	a_min_read: assert property (p_min_read) else $error("minimum read cycle wrong");
	property p_write_hold;
		(!sq.busy && sq.start && sq.is_write && sq.strobe_w == 4'h1 && sq.setup_w == 2'h0 && sq.hold_w == 2'h3)
			|=> s_wr_long;
	endproperty
	a_write_hold: assert property (p_write_hold) else $error("write hold length wrong");
	property p_order;
		$rose(sq.strobe_on) |-> $past(sq.setup_on);
	endproperty
	a_order: assert property (p_order) else $error("strobe not after setup");
endmodule
`default_nettype wire

// ===== core/ppt_flags.sv
// Slave buffer status flags: per-buffer full/empty plus overflow and underflow.
`timescale 1ns/1ps
`default_nettype none
module ppt_flags (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic slave_en,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [1:0] host_idx,
	input wire logic [ppt_pkg::NBUF-1:0] sw_in_rd,
	input wire logic [ppt_pkg::NBUF-1:0] sw_out_wr,
	input wire logic clr_in_ovf,
	input wire logic clr_out_unf,
	output logic [ppt_pkg::NBUF-1:0] in_full,
	output logic [ppt_pkg::NBUF-1:0] out_empty,
	output logic in_ovf,
	output logic out_unf
);
	import ppt_pkg::*;
	typedef struct packed {
		logic [NBUF-1:0] inf;
		logic [NBUF-1:0] oute;
		logic ov;
		logic uf;
	} ppt_flags_s;
	ppt_flags_s r_reg, r_next;

	always_comb begin
		logic hw;
		logic hr;
		r_next = r_reg;
		hw = 1'b0;
		hr = 1'b0;
		if (clr_in_ovf) r_next.ov = 1'b0;
		if (clr_out_unf) r_next.uf = 1'b0;
		for (int i = 0; i < NBUF; i++) begin
			// Host events only count in slave modes.
			hw = slave_en && host_wr && (host_idx == i[1:0]);
			hr = slave_en && host_rd && (host_idx == i[1:0]);
			if (sw_in_rd[i]) r_next.inf[i] = 1'b0;
			if (hw) r_next.inf[i] = 1'b1;
			if (hw && r_reg.inf[i]) r_next.ov = 1'b1;
			if (sw_out_wr[i]) r_next.oute[i] = 1'b0;
			if (hr) r_next.oute[i] = 1'b1;
			if (hr && r_reg.oute[i]) r_next.uf = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			r_reg <= '{inf: '0, oute: OUTE_RST, ov: 1'b0, uf: 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign in_full = r_reg.inf;
	assign out_empty = r_reg.oute;
	assign in_ovf = r_reg.ov;
	assign out_unf = r_reg.uf;
endmodule
`default_nettype wire

// ===== tb/ppt_host_model.sv
// Behavioural external host that writes input buffers and reads output buffers in slave modes.
`timescale 1ns/1ps
`default_nettype none
module ppt_host_model (
	input wire logic clk_sys,
	output logic host_wr,
	output logic host_rd,
	output logic [1:0] host_idx
);
	initial begin
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_idx = 2'h0;
	end
	// The index is inverted once released, so a block that latches it late sees a wrong buffer.
	task automatic put(input logic wr, input logic [1:0] idx);
		@(posedge clk_sys);
		host_wr <= wr;
		host_rd <= ~wr;
		host_idx <= idx;
		@(posedge clk_sys);
		host_wr <= 1'b0;
		host_rd <= 1'b0;
		host_idx <= ~idx;
	endtask
endmodule
`default_nettype wire

// ===== tb/ppt_top_bench.sv
// Self-checking testbench for the parallel port timing, address and status block.
`timescale 1ns/1ps
`default_nettype none
module ppt_top_bench;
	import ppt_pkg::*;
	logic clk_sys, rst, reg_wr, reg_rd, host_wr, host_rd;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [1:0] host_idx;
	logic [14:0] addr_pins, port_pin_owned;
	logic chip_select_pin, address_latch_high, address_latch_low, strobe_rd, strobe_wr;
	logic [3:0] inf, oute;
	logic ov, uf;
	int err_count, n_compared;

	ppt_top ppt_top_inst (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_wr(host_wr), .host_rd(host_rd),
		.host_idx(host_idx), .addr_pins(addr_pins), .port_pin_owned(port_pin_owned),
		.chip_select_pin(chip_select_pin), .address_latch_high(address_latch_high),
		.address_latch_low(address_latch_low), .strobe_rd(strobe_rd), .strobe_wr(strobe_wr));
	ppt_host_model ppt_host_model_inst (.clk_sys(clk_sys), .host_wr(host_wr), .host_rd(host_rd),
		.host_idx(host_idx));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ==========================================================
	// Bus, compare and closing tasks
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic settle();
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		logic [7:0] ofs [5] = '{OFS_MODE, OFS_ADDR, OFS_PEN, OFS_STAT, 8'hFC};
		logic [31:0] ones [5] = '{32'h7BFF, 32'h47FF, 32'h47FF, 32'h008F, 32'h0};
		logic [31:0] d;
		foreach (ofs[i]) begin
			rd(ofs[i], d);
			chk("reset_value", (ofs[i] == OFS_STAT) ? 32'h008F : 32'h0, d);
		end
		foreach (ofs[i]) begin
			wr(ofs[i], 32'hFFFF_FFFF);
			rd(ofs[i], d);
			chk("all_ones", ones[i], d);
		end
		settle();
		chk("pin_owned", 32'h47FF, {17'h0, port_pin_owned});
		wr(OFS_CTRL, 32'h0000_0080);
		wr(OFS_ADDR, 32'h0000_47FF);
		settle();
		chk("cs_pin", 32'h1, {31'h0, chip_select_pin});
		chk("addr_pins", 32'h7FF, {21'h0, addr_pins[10:0]});
		wr(OFS_CTRL, 32'h0000_0040);
		settle();
		chk("cs_pin", 32'h0, {31'h0, chip_select_pin});
		chk("addr14_pin", 32'h1, {31'h0, addr_pins[14]});
		wr(OFS_ADDR, 32'h0000_0003);
		wr(OFS_PEN, 32'h0000_0003);
		wr(OFS_CTRL, 32'h0000_1080);
		settle();
		chk("cs_pin", 32'h0, {31'h0, chip_select_pin});
		chk("pin_owned", 32'h3, {17'h0, port_pin_owned});
		chk("addr_low_pins", 32'h0, {30'h0, addr_pins[1:0]});
		$display("test regs done");
	endtask

	// Reads of the mode register run back to back so the busy bit is seen every cycle.
	task automatic run_cycle(input logic [1:0] md, wb, input logic [3:0] wm, input logic [1:0] we,
		input logic w, input logic [1:0] inc);
		int s, m, h, rise, wc, rc, bz, lt;
		logic act;
		s = (wm == 4'h0) ? 1 : wb + 1;
		m = wm + 1;
		h = w ? ((wm == 4'h0) ? 1 : we + 1) : ((wm == 4'h0) ? 0 : we);
		rise = 0;
		wc = 0;
		rc = 0;
		bz = 0;
		lt = 0;
		wr(OFS_MODE, {16'h0, 3'h0, inc, 1'b0, md, wb, wm, we});
		wr(OFS_CMD, {14'h0, w, 1'b1, 16'h0});
		reg_rd <= 1'b1;
		reg_addr <= OFS_MODE;
		for (int k = 1; k <= 40; k++) begin
			@(posedge clk_sys);
			#1;
			act = (md == MD_MASTER1 || w) ? strobe_wr : strobe_rd;
			if (act === 1'b1 && rise == 0) begin
				rise = k;
			end
			wc += (strobe_wr === 1'b1);
			rc += (strobe_rd === 1'b1);
			bz += (reg_rdata[MODE_BUSY] === 1'b1);
			lt += (address_latch_low === 1'b1) + (address_latch_high === 1'b1);
		end
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		chk("strobe_rise", s + 1, rise);
		chk("strobe_wr_len", (md == MD_MASTER1 || w) ? m : 0, wc);
		chk("strobe_rd_len", w ? 0 : ((md == MD_MASTER1) ? s + m + h : m), rc);
		chk("busy_len", s + m + h, bz);
		chk("latch_len", 2 * s, lt);
	endtask

	task automatic t_timing();
		wr(OFS_CTRL, 32'h0000_1000);
		run_cycle(MD_MASTER2, 2'h0, 4'h0, 2'h3, 1'b1, INC_NONE);
		run_cycle(MD_MASTER2, 2'h3, 4'h0, 2'h3, 1'b0, INC_NONE);
		run_cycle(MD_MASTER2, 2'h0, 4'h1, 2'h3, 1'b1, INC_NONE);
		run_cycle(MD_MASTER2, 2'h1, 4'hF, 2'h2, 1'b0, INC_NONE);
		run_cycle(MD_MASTER2, 2'h0, 4'h1, 2'h0, 1'b0, INC_NONE);
		run_cycle(MD_MASTER1, 2'h0, 4'h2, 2'h0, 1'b0, INC_NONE);
		run_cycle(MD_MASTER1, 2'h2, 4'h4, 2'h1, 1'b1, INC_NONE);
		$display("test timing done");
	endtask

	task automatic step(input logic [31:0] ctl, input logic [14:0] a0, input logic [1:0] inc,
		input logic [14:0] ex);
		logic [31:0] d;
		wr(OFS_CTRL, ctl);
		wr(OFS_ADDR, {17'h0, a0});
		run_cycle(MD_MASTER2, 2'h0, 4'h0, 2'h0, 1'b1, inc);
		rd(OFS_ADDR, d);
		chk("addr_after_cycle", {17'h0, ex}, d);
	endtask

	task automatic t_step();
		step(32'h0000_1000, 15'h07FC, INC_UP, 15'h4000);
		step(32'h0000_1000, 15'h4000, INC_DOWN, 15'h07FC);
		step(32'h0000_1080, 15'h47FC, INC_UP, 15'h4000);
		step(32'h0000_1000, 15'h0123, INC_NONE, 15'h0123);
		step(32'h0000_1000, 15'h0123, INC_SLAVE, 15'h0123);
		$display("test step done");
	endtask

	task automatic chkstat();
		logic [31:0] d;
		rd(OFS_STAT, d);
		chk("status", {16'h0, &inf, ov, 2'b0, inf, &oute, uf, 2'b0, oute}, d);
	endtask

	task automatic t_flags();
		inf = 4'h0;
		oute = 4'hF;
		ov = 1'b0;
		uf = 1'b0;
		wr(OFS_MODE, 32'h0);
		for (int i = 0; i < 4; i++) begin
			ppt_host_model_inst.put(1'b1, i[1:0]);
			inf[i] = 1'b1;
			chkstat();
		end
		ppt_host_model_inst.put(1'b1, 2'h2);
		ov = 1'b1;
		chkstat();
		wr(OFS_CMD, 32'h0000_0400);
		inf[2] = 1'b0;
		chkstat();
		wr(OFS_STAT, 32'h0);
		ov = 1'b0;
		chkstat();
		wr(OFS_CMD, 32'h0000_0005);
		oute = 4'hA;
		chkstat();
		ppt_host_model_inst.put(1'b0, 2'h0);
		oute[0] = 1'b1;
		chkstat();
		ppt_host_model_inst.put(1'b0, 2'h1);
		uf = 1'b1;
		chkstat();
		wr(OFS_STAT, 32'h0000_4000);
		uf = 1'b0;
		chkstat();
		// Host strobes in a master mode must leave every flag alone.
		wr(OFS_MODE, 32'h0000_0200);
		ppt_host_model_inst.put(1'b1, 2'h2);
		ppt_host_model_inst.put(1'b0, 2'h2);
		chkstat();
		$display("test flags done");
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		err_count = 0;
		n_compared = 0;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		t_regs();
		t_timing();
		t_step();
		t_flags();
		print_verdict();
	end

	// The tests need under two thousand cycles; three times that means a hang.
	initial begin
		repeat (6000) @(posedge clk_sys);
		err_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
